// ### hdl/ircag_pkg.sv
// package of the ir carrier auto-gating block: register map, field
// positions, reset values, carrier divider counts and shared types.
// assumes a 10 MHz system clock and a 32-bit classic wishbone bus.
package ircag_pkg;

   // register byte addresses
   localparam logic [7:0] IRCAG_ADDR_CTRL = 8'h00;
   localparam logic [7:0] IRCAG_ADDR_SEL = 8'h04;
   localparam logic [7:0] IRCAG_ADDR_CMD = 8'h08;
   localparam logic [7:0] IRCAG_ADDR_T1 = 8'h0C;
   localparam logic [7:0] IRCAG_ADDR_STAT = 8'h10;

   // control register fields
   localparam int IRCAG_CTRL_AUTO_BIT = 0;
   localparam int IRCAG_CTRL_RUN_BIT = 1;
   localparam int IRCAG_CTRL_SRC_LSB = 2;
   // command register fields (write-only strobes)
   localparam int IRCAG_CMD_START_BIT = 0;
   localparam int IRCAG_CMD_STOP_BIT = 1;
   // status register fields
   localparam int IRCAG_STAT_RUN_BIT = 0;
   localparam int IRCAG_STAT_GATE_BIT = 1;
   localparam int IRCAG_STAT_FROZEN_BIT = 2;
   localparam int IRCAG_STAT_PIN_BIT = 3;
   localparam int IRCAG_STAT_CNT_LSB = 8;

   // timer 1 count sources
   localparam logic [1:0] IRCAG_SRC_CARRIER = 2'h0;
   localparam logic [1:0] IRCAG_SRC_CARRIER_DIV2 = 2'h1;
   localparam logic [1:0] IRCAG_SRC_PRESCALER = 2'h2;

   // reset values
   localparam logic [1:0] IRCAG_SEL_RESET = 2'h0;
   localparam logic [7:0] IRCAG_T1_RESET = 8'hFF;

   // carrier frequencies in hz and the clock rate
   localparam int IRCAG_CLK_HZ = 10000000;
   localparam int IRCAG_CAR0_HZ = 38000;
   localparam int IRCAG_CAR1_HZ = 40000;
   localparam int IRCAG_CAR2_HZ = 36000;
   localparam int IRCAG_CAR3_HZ = 57000;
   // half-period counts, rounded down, at least one cycle
   localparam logic [11:0] IRCAG_HALF0 =
      12'(IRCAG_CLK_HZ / (2 * IRCAG_CAR0_HZ));
   localparam logic [11:0] IRCAG_HALF1 =
      12'(IRCAG_CLK_HZ / (2 * IRCAG_CAR1_HZ));
   localparam logic [11:0] IRCAG_HALF2 =
      12'(IRCAG_CLK_HZ / (2 * IRCAG_CAR2_HZ));
   localparam logic [11:0] IRCAG_HALF3 =
      12'(IRCAG_CLK_HZ / (2 * IRCAG_CAR3_HZ));

   typedef struct packed {
      logic [1:0] src;
      logic run;
      logic auto_en;
   } ircag_ctrl_t;

   localparam ircag_ctrl_t IRCAG_CTRL_RESET = '{2'h0, 1'b0, 1'b0};

   typedef enum logic [2:0] {
      IRCAG_GATE_IDLE = 3'h1,
      IRCAG_GATE_AUTO = 3'h2,
      IRCAG_GATE_FROZEN = 3'h4
   } ircag_gate_t;

endpackage : ircag_pkg

// ### hdl/ircag_timer1.sv
// timer 1: 8-bit down counter with reload register and underflow pulse.
// assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module ircag_timer1
   import ircag_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic run,
   input wire logic tick,
   input wire logic wr,
   input wire logic [7:0] wr_data,
   output logic [7:0] count,
   output logic underflow
);

   logic [7:0] count_reg;
   logic [7:0] reload_reg;
   logic underflow_reg;
   wire at_zero = (count_reg == 8'h00);
   wire under_now = run && tick && at_zero;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_reg <= IRCAG_T1_RESET;
         reload_reg <= IRCAG_T1_RESET;
         underflow_reg <= 1'b0;
      end else begin
         underflow_reg <= under_now;
         // stopped: write sets counter and reload; running: reload only
         if (wr) begin
            reload_reg <= wr_data;
         end
         if (wr && !run) begin
            count_reg <= wr_data;
         end else if (under_now) begin
            count_reg <= reload_reg;
         end else if (run && tick) begin
            count_reg <= count_reg - 8'h01;
         end
      end
   end

   assign count = count_reg;
   assign underflow = underflow_reg;

endmodule : ircag_timer1

// ### hdl/ircag_top.sv
// ir carrier generator with timer 1 auto-gating, wishbone register slave.
// assumes a 10 MHz clock; prescaler_out_clock comes from another domain.
//
// Behaviour
// - auto gate enable hands pin to timer
// - timer counts when run bit written one
// - carrier drives pin until first underflow
// - first underflow disables pin, reloads timer
// - later underflows toggle enable and disable
// - clearing auto enable freezes pin state
// - freeze released by timer stop or re-enable
// - re-enabling resumes at next underflow
// - start/stop commands set/clear run flag
// - reset clears carrier run flag
// - stop while high truncates final high
// - selection register picks carrier waveform
// - eight-bit down counter, divide by n+1
// - carriers divided from system clock
//
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module ircag_top
   import ircag_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic prescaler_out_clock,
   output logic modulated_output_pin
);

   function automatic logic [11:0] half_count(input logic [1:0] sel);
      case (sel)
         2'h0: half_count = IRCAG_HALF0;
         2'h1: half_count = IRCAG_HALF1;
         2'h2: half_count = IRCAG_HALF2;
         default: half_count = IRCAG_HALF3;
      endcase
   endfunction : half_count

   // registers
   ircag_ctrl_t ctrl_reg;
   logic [1:0] carrier_select_reg;
   logic carrier_run_flag;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [11:0] div_reg;
   logic carrier_reg;
   logic carrier_d_reg;
   logic div2_reg;
   logic div2_d_reg;
   logic pre_s1_reg;
   logic pre_s2_reg;
   logic pre_d_reg;
   ircag_gate_t gate_reg;
   ircag_gate_t gate_next;
   logic gate_on_reg;
   logic gate_on_next;
   logic pin_reg;

   // bus decode
   wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
   wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
   wire hit_ctrl = (wb_adr_i == IRCAG_ADDR_CTRL);
   wire hit_sel = (wb_adr_i == IRCAG_ADDR_SEL);
   wire hit_cmd = (wb_adr_i == IRCAG_ADDR_CMD);
   wire hit_t1 = (wb_adr_i == IRCAG_ADDR_T1);
   wire hit_stat = (wb_adr_i == IRCAG_ADDR_STAT);
   wire wr_ctrl = bus_wr && hit_ctrl;
   wire wr_sel = bus_wr && hit_sel;
   wire wr_t1 = bus_wr && hit_t1;
   wire start_cmd = bus_wr && hit_cmd && wb_dat_i[IRCAG_CMD_START_BIT];
   wire stop_cmd = bus_wr && hit_cmd && wb_dat_i[IRCAG_CMD_STOP_BIT];

   // carrier divider
   wire [11:0] half = half_count(carrier_select_reg);
   wire div_wrap = (div_reg >= half - 12'h001);
   wire carrier_rise = carrier_reg && !carrier_d_reg;
   wire div2_rise = div2_reg && !div2_d_reg;
   wire pre_rise = pre_s2_reg && !pre_d_reg;

   // timer 1 count source; prescaler edges are not carrier-aligned
   wire t1_tick = (ctrl_reg.src == IRCAG_SRC_CARRIER) ? carrier_rise :
                  (ctrl_reg.src == IRCAG_SRC_CARRIER_DIV2) ? div2_rise :
                  (ctrl_reg.src == IRCAG_SRC_PRESCALER) ? pre_rise :
                  1'b0;
   wire [7:0] t1_count;
   wire t1_under;

   ircag_timer1 u_timer1 (
      .clock(clock),
      .resetn(resetn),
      .run(ctrl_reg.run),
      .tick(t1_tick),
      .wr(wr_t1),
      .wr_data(wb_dat_i[7:0]),
      .count(t1_count),
      .underflow(t1_under)
   );

   wire gate_open = (gate_reg == IRCAG_GATE_IDLE) || gate_on_reg;
   wire pin_next = carrier_run_flag && carrier_reg && gate_open;

   wire [31:0] stat_word = {16'h0000, t1_count, 4'h0,
                            pin_reg, gate_reg == IRCAG_GATE_FROZEN,
                            gate_on_reg, carrier_run_flag};
   wire [31:0] rd_word =
      hit_ctrl ? {28'h0000000, ctrl_reg.src, ctrl_reg.run,
                  ctrl_reg.auto_en} :
      hit_sel ? {30'h00000000, carrier_select_reg} :
      hit_cmd ? {31'h00000000, carrier_run_flag} :
      hit_t1 ? {24'h000000, t1_count} :
      hit_stat ? stat_word : 32'h00000000;

   // gating state machine
   always_comb begin
      gate_next = gate_reg;
      gate_on_next = gate_on_reg;
      case (gate_reg)
         IRCAG_GATE_IDLE: begin
            gate_on_next = 1'b1;
            if (ctrl_reg.run && ctrl_reg.auto_en) begin
               gate_next = IRCAG_GATE_AUTO;
            end
         end
         IRCAG_GATE_AUTO: begin
            if (!ctrl_reg.run) begin
               gate_next = IRCAG_GATE_IDLE;
            end else if (!ctrl_reg.auto_en) begin
               gate_next = IRCAG_GATE_FROZEN;
            end else if (t1_under) begin
               gate_on_next = !gate_on_reg;
            end
         end
         IRCAG_GATE_FROZEN: begin
            if (!ctrl_reg.run) begin
               gate_next = IRCAG_GATE_IDLE;
            end else if (ctrl_reg.auto_en && t1_under) begin
               gate_next = IRCAG_GATE_AUTO;
               gate_on_next = !gate_on_reg;
            end
         end
         default: begin
            gate_next = IRCAG_GATE_IDLE;
            gate_on_next = 1'b1;
         end
      endcase
   end

   // bus slave and control registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
         ctrl_reg <= IRCAG_CTRL_RESET;
         carrier_select_reg <= IRCAG_SEL_RESET;
      end else begin
         ack_reg <= bus_req;
         if (bus_req) begin
            dat_reg <= rd_word;
         end
         if (wr_ctrl) begin
            ctrl_reg.auto_en <= wb_dat_i[IRCAG_CTRL_AUTO_BIT];
            ctrl_reg.run <= wb_dat_i[IRCAG_CTRL_RUN_BIT];
            ctrl_reg.src <= wb_dat_i[IRCAG_CTRL_SRC_LSB +: 2];
         end
         if (wr_sel) begin
            carrier_select_reg <= wb_dat_i[1:0];
         end
      end
   end

   // carrier run flag; stop wins if both strobes are written together
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         carrier_run_flag <= 1'b0;
      end else if (stop_cmd) begin
         carrier_run_flag <= 1'b0;
      end else if (start_cmd) begin
         carrier_run_flag <= 1'b1;
      end
   end

   // carrier generation; stopping clears the level at once, so a high
   // half period in progress is cut short
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div_reg <= 12'h000;
         carrier_reg <= 1'b0;
         carrier_d_reg <= 1'b0;
         div2_reg <= 1'b0;
         div2_d_reg <= 1'b0;
      end else begin
         carrier_d_reg <= carrier_reg;
         div2_d_reg <= div2_reg;
         if (!carrier_run_flag) begin
            div_reg <= 12'h000;
            carrier_reg <= 1'b0;
            div2_reg <= 1'b0;
         end else if (div_wrap) begin
            div_reg <= 12'h000;
            carrier_reg <= !carrier_reg;
            if (!carrier_reg) begin
               div2_reg <= !div2_reg;
            end
         end else begin
            div_reg <= div_reg + 12'h001;
         end
      end
   end

   // prescaler clock synchroniser and edge detect
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pre_s1_reg <= 1'b0;
         pre_s2_reg <= 1'b0;
         pre_d_reg <= 1'b0;
      end else begin
         pre_s1_reg <= prescaler_out_clock;
         pre_s2_reg <= pre_s1_reg;
         pre_d_reg <= pre_s2_reg;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gate_reg <= IRCAG_GATE_IDLE;
         gate_on_reg <= 1'b1;
         pin_reg <= 1'b0;
      end else begin
         gate_reg <= gate_next;
         gate_on_reg <= gate_on_next;
         pin_reg <= pin_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign modulated_output_pin = pin_reg;

endmodule : ircag_top

// ### test/ircag_assertions.sv
// checker of ircag_top: bus handshake and pin relations.
// assumes it is bound to ircag_top and sees its ports only.
`timescale 1ns/1ps
module ircag_assertions
   import ircag_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic modulated_output_pin
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   logic take;
   logic wr0;
   logic run_reg;
   logic [1:0] ctrl_reg;
   logic [7:0] hi_reg;
   assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr0 = take & wb_we_i & wb_sel_i[0];
   // shadows follow the design's own take edge, so no extra latency
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         run_reg <= 1'b0;
         ctrl_reg <= 2'h0;
         hi_reg <= 8'h00;
      end else begin
         if (wr0 && wb_adr_i == IRCAG_ADDR_CMD)
            run_reg <= ~wb_dat_i[1] & (wb_dat_i[0] | run_reg);
         if (wr0 && wb_adr_i == IRCAG_ADDR_CTRL)
            ctrl_reg <= wb_dat_i[1:0];
         hi_reg <= modulated_output_pin ? hi_reg + 8'h01 : 8'h00;
      end
   end
   a_ack_next: assert property (take |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(take))
      else $error("ack without request");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i > IRCAG_ADDR_STAT |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_stopped_low: assert property (
      !run_reg && !$past(run_reg) && !$past(run_reg, 2)
      |-> !modulated_output_pin) else $error("pin high while stopped");
   a_rise_needs_run: assert property (
      $rose(modulated_output_pin) |-> $past(run_reg))
      else $error("pin rose without run flag");
   a_start_drives: assert property (
      wr0 && wb_adr_i == IRCAG_ADDR_CMD && wb_dat_i[1:0] == 2'h1 &&
      ctrl_reg == 2'h0 |-> ##[1:300] modulated_output_pin)
      else $error("carrier absent after start");
   a_high_bounded: assert property (
      hi_reg <= 8'(IRCAG_HALF2)) else $error("high phase too long");
endmodule : ircag_assertions
bind ircag_top ircag_assertions ircag_assertions_inst (.clock, .resetn,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .modulated_output_pin);

// ### test/ircag_emitter.sv
// emitter model: measures high and low runs of the modulated pin.
// assumes the pin is sampled on the block clock; it drives nothing.
`timescale 1ns/1ps
module ircag_emitter (
   input wire logic clock,
   input wire logic resetn,
   input wire logic led_drive,
   output int n_rise,
   output int last_high,
   output int last_low,
   output int cur_len
);
   logic prev;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prev <= 1'b0;
         n_rise <= 0;
         cur_len <= 0;
         last_high <= 0;
         last_low <= 0;
      end else if (led_drive !== prev) begin
         if (prev)
            last_high <= cur_len;
         else
            last_low <= cur_len;
         n_rise <= n_rise + int'(led_drive);
         cur_len <= 1;
         prev <= led_drive;
      end else begin
         cur_len <= cur_len + 1;
      end
   end
endmodule : ircag_emitter

// ### test/test_ircag_top.sv
// bench of ircag_top: bus tasks, read queue, pin timing.
// assumes the emitter model watches the pin.
`timescale 1ns/1ps
module test_ircag_top;
   import ircag_pkg::*;
   logic clock, resetn, cyc, stb, we, ack, pin, pre;
   logic [3:0] sel;
   logic [7:0] adr, rl;
   logic [31:0] dat_w, dat_r;
   logic [31:0] exp_q[$];
   logic [11:0] half[4];
   int n_mismatch, checked, n_rise, last_high, last_low, cur_len, b, gap;
   ircag_top ircag_top_inst (.clock, .resetn, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .prescaler_out_clock(pre), .modulated_output_pin(pin));
   // unrelated clock on the prescaler pin; never picked as source here
   always @(posedge clock) pre <= 1'($urandom % 2);
   ircag_emitter ircag_emitter_inst (.clock, .resetn, .led_drive(pin),
      .n_rise, .last_high, .last_low, .cur_len);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] expv);
      checked++;
      if (seen !== expv) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, expv, seen);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      // hold the request until the rising edge that samples ack high
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (ack === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         report_and_stop();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask : rd
   // wait for k more rises, then if len > 0 for a low run above len
   task automatic wait_for(input int k, input int len);
      int i;
      int s;
      s = n_rise;
      for (i = 0; i < 30000 && (n_rise < s + k || (len > 0 &&
         !(pin === 1'b0 && cur_len > len))); i++) @(negedge clock);
      if (i == 30000) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask : wait_for
   // read data is taken at the same edge that samples ack high
   always @(posedge clock) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         check("read data", dat_r, exp_q.pop_front());
      end
   end
   initial begin
      {resetn, cyc, stb, we, adr, dat_w} = '0;
      sel = 4'hF;
      n_mismatch = 0;
      checked = 0;
      half = '{IRCAG_HALF0, IRCAG_HALF1, IRCAG_HALF2, IRCAG_HALF3};
      rl = 8'(2 + $urandom(32'hD075730C) % 4);
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      rd(IRCAG_ADDR_CTRL, 32'h0);
      rd(IRCAG_ADDR_CMD, 32'h0);
      rd(IRCAG_ADDR_T1, 32'hFF);
      wb(1'b1, 8'h14, 32'hFF);
      rd(8'h14, 32'h0);
      $display("reset test done");
      for (int s = 0; s < 4; s++) begin
         wb(1'b1, IRCAG_ADDR_SEL, 32'(s));
         rd(IRCAG_ADDR_SEL, 32'(s));
         wb(1'b1, IRCAG_ADDR_CMD, 32'h1);
         wait_for(2, 0);
         check("high run", 32'(last_high), 32'(half[s]));
         check("low run", 32'(last_low), 32'(half[s]));
         wait_for(0, 2);
         wb(1'b1, IRCAG_ADDR_CMD, 32'h2);
         rd(IRCAG_ADDR_CMD, 32'h0);
      end
      $display("carrier test done");
      wb(1'b1, IRCAG_ADDR_SEL, 32'h0);
      wb(1'b1, IRCAG_ADDR_T1, 32'h3);
      wb(1'b1, IRCAG_ADDR_CTRL, 32'h3);
      wb(1'b1, IRCAG_ADDR_T1, 32'(rl));
      wb(1'b1, IRCAG_ADDR_CMD, 32'h1);
      gap = (int'(rl) + 1) * 2 * int'(IRCAG_HALF0);
      wait_for(1, 400);
      wait_for(1, 0);
      b = n_rise - 1;
      check("gap", 32'(last_low >= gap - 4 && last_low <= gap + 4), 1);
      wait_for(0, 400);
      check("pulses", 32'(n_rise - b >= rl && n_rise - b <= rl + 2), 1);
      wb(1'b1, IRCAG_ADDR_CTRL, 32'h2);
      b = n_rise;
      repeat (3 * gap) @(posedge clock);
      check("frozen", 32'(n_rise), 32'(b));
      wb(1'b1, IRCAG_ADDR_CTRL, 32'h0);
      wait_for(1, 0);
      wait_for(0, 2);
      wb(1'b1, IRCAG_ADDR_CMD, 32'h2);
      rd(IRCAG_ADDR_CTRL, 32'h0);
      $display("auto gating test done");
      report_and_stop();
   end
endmodule : test_ircag_top
